// File: hw/i2c_ms_pkg.sv
/*
 Package for the I2C master/slave register block: register indices,
 field positions, reset values, state encodings and pad structs.
 Assumes APB byte address = 4 * register index.
*/
package i2c_ms_pkg;
   localparam logic [7:0] MCTRL_IDX = 8'he1;
   localparam logic [7:0] MDATA_IDX = 8'he2;
   localparam logic [7:0] SADDR_IDX = 8'he9;
   localparam logic [7:0] SCTRL_IDX = 8'hea;
   localparam logic [7:0] SRX1_IDX = 8'heb;
   localparam logic [7:0] SSHARED_IDX = 8'hec;
   localparam logic [7:0] ISTAT_IDX = 8'hf8;
   localparam logic [7:0] ICLR_IDX = 8'hf9;
   localparam logic [7:0] IEN_IDX = 8'hfa;
   // Master control fields
   localparam int M_EN_B = 7;
   localparam int M_ACKO_B = 6;
   localparam int M_DONE_B = 5;
   localparam int M_ACKI_B = 4;
   localparam int M_START_B = 3;
   localparam int M_STOP_B = 2;
   // Slave control fields
   localparam int S_MIE_B = 7;
   localparam int S_TXIE_B = 6;
   localparam int S_RX2IE_B = 5;
   localparam int S_RX1IE_B = 4;
   localparam int S_SLAVE_TX_DONE_FLAG_B = 2;
   localparam int S_RX2F_B = 1;
   localparam int S_RX1F_B = 0;
   localparam int SADDR_EN_B = 0;
   // Interrupt status bit order
   localparam int EV_MDONE = 0;
   localparam int EV_STX = 1;
   localparam int EV_SRX2 = 2;
   localparam int EV_SRX1 = 3;
   localparam int EV_N = 4;
   // Reset values
   localparam logic [7:0] MDATA_RST = 8'h00;
   localparam logic [6:0] OWN_ADDR_RST = 7'h32;
   localparam logic [1:0] RATE_RST = 2'h0;
   localparam logic STOP_RST = 1'b1;
   localparam logic SLAVE_TX_DONE_FLAG_RST = 1'b1;
   localparam logic [7:0] RDATA_RST = 8'h00;

   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_START = 3'b001,
      M_HOLD = 3'b010,
      M_BIT = 3'b011,
      M_STOP = 3'b100
   } mstate_e;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_ACK = 3'b010,
      S_RX = 3'b011,
      S_TX = 3'b100,
      S_TXACK = 3'b101
   } sstate_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } pad_in_s;

   typedef struct packed {
      logic scl_o;
      logic scl_oe_n;
      logic sda_o;
      logic sda_oe_n;
   } pad_out_s;
endpackage : i2c_ms_pkg

// File: hw/i2c_master_slave_regs.sv
/*
 I2C master engine, I2C slave and their registers behind an APB slave.
 Assumes open-drain pads resolved outside; pins are asynchronous.
*/
// Summary of operation
// RQ1: Master runs only while master_enable set
// RQ2: Received byte answered with ack_out_select bit
// RQ3: Byte done sets master_done_flag; write 0 clears
// RQ4: Bus acknowledge captured into ack_in_status
// RQ5: Writing master_start_bit issues a START
// RQ6: Writing master_stop_bit issues a STOP
// RQ7: SCL is pclk divided by 4/16/64/256
// RQ8: Data write resumes transmitting that byte
// RQ9: Data read returns byte, resumes receiving
// RQ10: Slave answers its 7-bit own address
// RQ11: Slave active only while slave_enable set
// RQ12: Master interrupt gated by master_irq_enable, or by IEN bit 0 through the status register
// RQ13: Slave transmit interrupt gated by its enable
// RQ14: Second-byte receive interrupt gated by enable
// RQ15: First-byte receive interrupt gated by enable
// RQ16: Slave transmit done flag, write 0 clears
// RQ17: Shared data: read second byte, write transmit
// RQ18: Master interrupt held until flag cleared
`timescale 1ns/10ps
module i2c_master_slave_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire i2c_ms_pkg::pad_in_s pad_in,
   output i2c_ms_pkg::pad_out_s pad_out,
   output logic irq
);
   function automatic logic [7:0] quarter_len(input logic [1:0] rate);
      quarter_len = 8'h01 << {rate, 1'b0};
   endfunction : quarter_len

   function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
      hit = (a == {i, 2'b00});
   endfunction : hit

   logic pready_reg, pslverr_reg, irq_reg;
   logic [31:0] prdata_reg;
   logic [7:0] rd_mux;
   logic mapped;
   logic acc, wr, rd;
   // Control registers
   logic m_en_reg, m_acko_reg, m_done_reg, m_acki_reg;
   logic m_start_reg, m_stop_reg;
   logic [1:0] rate_reg;
   logic [7:0] mshift_reg;
   logic [6:0] own_addr_reg;
   logic s_en_reg;
   logic [3:0] s_ie_reg;
   logic s_slave_tx_done_flag_reg, s_rx2f_reg, s_rx1f_reg;
   logic [7:0] s_rx1_reg, s_rx2_reg, s_tx_reg;
   logic [i2c_ms_pkg::EV_N-1:0] istat_reg, ien_reg, ev;
   // Master engine
   i2c_ms_pkg::mstate_e m_state_reg;
   logic [7:0] qcnt_reg;
   logic [1:0] ph_reg;
   logic [3:0] mbit_reg;
   logic m_rx_reg, m_scl_low_reg, m_sda_low_reg, m_done_ev;
   logic tick;
   // Slave engine
   i2c_ms_pkg::sstate_e s_state_reg;
   logic scl_s1, scl_s2, sda_s1, sda_s2, scl_d, sda_d;
   logic [7:0] sshift_reg;
   logic [3:0] scnt_reg;
   logic s_rw_reg, s_first_reg, s_match_reg, s_sda_low_reg;
   logic s_tx_ev, s_rx1_ev, s_rx2_ev;
   logic rise, fall, start_det, stop_det;
   logic [7:0] rx_byte;
   i2c_ms_pkg::pad_out_s pad_reg;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pad_out = pad_reg;
   assign irq = irq_reg;

   // APB: one wait state, transfer completes when pready was set
   assign acc = ce & psel & penable & pready_reg;
   assign wr = acc & pwrite & mapped;
   assign rd = acc & ~pwrite & mapped;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 8'h00;
      if (hit(paddr, i2c_ms_pkg::MCTRL_IDX)) begin
         rd_mux = {m_en_reg, m_acko_reg, m_done_reg, m_acki_reg,
            m_start_reg, m_stop_reg, rate_reg};
      end else if (hit(paddr, i2c_ms_pkg::MDATA_IDX)) begin
         rd_mux = mshift_reg;
      end else if (hit(paddr, i2c_ms_pkg::SADDR_IDX)) begin
         rd_mux = {own_addr_reg, s_en_reg};
      end else if (hit(paddr, i2c_ms_pkg::SCTRL_IDX)) begin
         rd_mux = {s_ie_reg, 1'b0, s_slave_tx_done_flag_reg, s_rx2f_reg, s_rx1f_reg};
      end else if (hit(paddr, i2c_ms_pkg::SRX1_IDX)) begin
         rd_mux = s_rx1_reg;
      end else if (hit(paddr, i2c_ms_pkg::SSHARED_IDX)) begin
         rd_mux = s_rx2_reg; // [RQ17]
      end else if (hit(paddr, i2c_ms_pkg::ISTAT_IDX)) begin
         rd_mux = {4'h0, istat_reg};
      end else if (hit(paddr, i2c_ms_pkg::IEN_IDX)) begin
         rd_mux = {4'h0, ien_reg};
      end else if (!hit(paddr, i2c_ms_pkg::ICLR_IDX)) begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else if (ce) begin
         pready_reg <= psel & penable & ~pready_reg;
         if (psel && penable && !pready_reg) begin
            pslverr_reg <= ~mapped;
            prdata_reg <= {24'h0, rd_mux};
         end
      end
   end

   // Master control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_en_reg <= 1'b0;
         m_acko_reg <= 1'b0;
         m_done_reg <= 1'b0;
         m_start_reg <= 1'b0;
         m_stop_reg <= i2c_ms_pkg::STOP_RST;
         rate_reg <= i2c_ms_pkg::RATE_RST;
      end else if (ce) begin
         if (wr && hit(paddr, i2c_ms_pkg::MCTRL_IDX)) begin
            m_en_reg <= pwdata[i2c_ms_pkg::M_EN_B];
            m_acko_reg <= pwdata[i2c_ms_pkg::M_ACKO_B];
            rate_reg <= pwdata[1:0];
            if (pwdata[i2c_ms_pkg::M_START_B])
               m_start_reg <= 1'b1; // [RQ5]
            if (pwdata[i2c_ms_pkg::M_STOP_B])
               m_stop_reg <= 1'b1; // [RQ6]
         end
         // Set wins over a simultaneous write of 0
         if (m_done_ev)
            m_done_reg <= 1'b1; // [RQ3]
         else if (wr && hit(paddr, i2c_ms_pkg::MCTRL_IDX)
               && !pwdata[i2c_ms_pkg::M_DONE_B])
            m_done_reg <= 1'b0; // [RQ3]
         if (m_state_reg == i2c_ms_pkg::M_START && tick
               && ph_reg == 2'd3) begin
            m_start_reg <= 1'b0;
            m_stop_reg <= 1'b0;
         end
         if (m_state_reg == i2c_ms_pkg::M_STOP && tick && ph_reg == 2'd3)
            m_stop_reg <= 1'b1;
      end
   end

   // Master engine: four quarter ticks per SCL period
   assign tick = (qcnt_reg == 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qcnt_reg <= 8'h00;
      end else if (ce) begin
         if (m_state_reg == i2c_ms_pkg::M_IDLE || !tick)
            qcnt_reg <= (m_state_reg == i2c_ms_pkg::M_IDLE) ? 8'h00
               : qcnt_reg - 8'h01;
         else
            qcnt_reg <= quarter_len(rate_reg) - 8'h01; // [RQ7]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_state_reg <= i2c_ms_pkg::M_IDLE;
         ph_reg <= 2'd0;
         mbit_reg <= 4'h0;
         m_rx_reg <= 1'b0;
         m_scl_low_reg <= 1'b0;
         m_sda_low_reg <= 1'b0;
         m_acki_reg <= 1'b0;
         mshift_reg <= i2c_ms_pkg::MDATA_RST;
         m_done_ev <= 1'b0;
      end else if (ce) begin
         m_done_ev <= 1'b0;
         if (wr && hit(paddr, i2c_ms_pkg::MDATA_IDX))
            mshift_reg <= pwdata[7:0]; // [RQ8]
         if (!m_en_reg) begin
            // Disabling drops the bus at once; no STOP is sent
            m_state_reg <= i2c_ms_pkg::M_IDLE; // [RQ1]
            m_scl_low_reg <= 1'b0;
            m_sda_low_reg <= 1'b0;
         end else begin
            case (m_state_reg)
               i2c_ms_pkg::M_IDLE: begin
                  ph_reg <= 2'd0;
                  if (m_start_reg)
                     m_state_reg <= i2c_ms_pkg::M_START; // [RQ5]
               end
               i2c_ms_pkg::M_HOLD: begin
                  ph_reg <= 2'd0;
                  mbit_reg <= 4'h0;
                  if (wr && hit(paddr, i2c_ms_pkg::MDATA_IDX)) begin
                     m_rx_reg <= 1'b0;
                     m_state_reg <= i2c_ms_pkg::M_BIT; // [RQ8]
                  end else if (rd && hit(paddr, i2c_ms_pkg::MDATA_IDX)) begin
                     m_rx_reg <= 1'b1;
                     m_state_reg <= i2c_ms_pkg::M_BIT; // [RQ9]
                  end else if (m_start_reg) begin
                     m_state_reg <= i2c_ms_pkg::M_START;
                  end else if (m_stop_reg) begin
                     m_state_reg <= i2c_ms_pkg::M_STOP; // [RQ6]
                  end
               end
               i2c_ms_pkg::M_START: if (tick) begin
                  ph_reg <= ph_reg + 2'd1;
                  case (ph_reg)
                     2'd0: m_sda_low_reg <= 1'b0;
                     2'd1: m_scl_low_reg <= 1'b0;
                     2'd2: m_sda_low_reg <= 1'b1; // [RQ5]
                     default: begin
                        m_scl_low_reg <= 1'b1;
                        m_state_reg <= i2c_ms_pkg::M_HOLD;
                     end
                  endcase
               end
               i2c_ms_pkg::M_BIT: if (tick) begin
                  ph_reg <= ph_reg + 2'd1;
                  case (ph_reg)
                     2'd0: begin
                        if (mbit_reg[3])
                           m_sda_low_reg <= m_rx_reg & ~m_acko_reg; // [RQ2]
                        else
                           m_sda_low_reg <= ~m_rx_reg & ~mshift_reg[7];
                     end
                     2'd1: m_scl_low_reg <= 1'b0;
                     2'd2: begin
                        if (!mbit_reg[3])
                           mshift_reg <= {mshift_reg[6:0],
                              m_rx_reg ? sda_s2 : 1'b0};
                        else if (!m_rx_reg)
                           m_acki_reg <= sda_s2; // [RQ4]
                     end
                     default: begin
                        m_scl_low_reg <= 1'b1;
                        mbit_reg <= mbit_reg + 4'h1;
                        if (mbit_reg[3]) begin
                           m_sda_low_reg <= 1'b0;
                           m_done_ev <= 1'b1; // [RQ3]
                           m_state_reg <= i2c_ms_pkg::M_HOLD;
                        end
                     end
                  endcase
               end
               i2c_ms_pkg::M_STOP: if (tick) begin
                  ph_reg <= ph_reg + 2'd1;
                  case (ph_reg)
                     2'd0: m_sda_low_reg <= 1'b1;
                     2'd1: m_scl_low_reg <= 1'b0;
                     2'd2: m_sda_low_reg <= 1'b0; // [RQ6]
                     default: m_state_reg <= i2c_ms_pkg::M_IDLE;
                  endcase
               end
               default: m_state_reg <= i2c_ms_pkg::M_IDLE;
            endcase
         end
      end
   end

   // Pin synchronisers and slave bus events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (ce) begin
         scl_s1 <= pad_in.scl;
         scl_s2 <= scl_s1;
         sda_s1 <= pad_in.sda;
         sda_s2 <= sda_s1;
         scl_d <= scl_s2;
         sda_d <= sda_s2;
      end
   end

   assign rise = scl_s2 & ~scl_d;
   assign fall = ~scl_s2 & scl_d;
   assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign rx_byte = {sshift_reg[6:0], sda_s2};

   // Slave address and control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         own_addr_reg <= i2c_ms_pkg::OWN_ADDR_RST;
         s_en_reg <= 1'b0;
         s_ie_reg <= 4'h0;
         s_tx_reg <= i2c_ms_pkg::RDATA_RST;
      end else if (ce && wr) begin
         if (hit(paddr, i2c_ms_pkg::SADDR_IDX)) begin
            own_addr_reg <= pwdata[7:1]; // [RQ10]
            s_en_reg <= pwdata[i2c_ms_pkg::SADDR_EN_B]; // [RQ11]
         end
         if (hit(paddr, i2c_ms_pkg::SCTRL_IDX))
            s_ie_reg <= pwdata[7:4];
         if (hit(paddr, i2c_ms_pkg::SSHARED_IDX))
            s_tx_reg <= pwdata[7:0]; // [RQ17]
      end
   end

   // Slave flags: hardware set wins over a write of 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_slave_tx_done_flag_reg <= i2c_ms_pkg::SLAVE_TX_DONE_FLAG_RST;
         s_rx2f_reg <= 1'b0;
         s_rx1f_reg <= 1'b0;
      end else if (ce) begin
         if (s_tx_ev)
            s_slave_tx_done_flag_reg <= 1'b1; // [RQ16]
         else if (wr && hit(paddr, i2c_ms_pkg::SCTRL_IDX)
               && !pwdata[i2c_ms_pkg::S_SLAVE_TX_DONE_FLAG_B])
            s_slave_tx_done_flag_reg <= 1'b0; // [RQ16]
         if (s_rx2_ev)
            s_rx2f_reg <= 1'b1;
         else if (wr && hit(paddr, i2c_ms_pkg::SCTRL_IDX)
               && !pwdata[i2c_ms_pkg::S_RX2F_B])
            s_rx2f_reg <= 1'b0;
         if (s_rx1_ev)
            s_rx1f_reg <= 1'b1;
         else if (wr && hit(paddr, i2c_ms_pkg::SCTRL_IDX)
               && !pwdata[i2c_ms_pkg::S_RX1F_B])
            s_rx1f_reg <= 1'b0;
      end
   end

   // Slave engine; no clock stretching, software must keep pace
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_state_reg <= i2c_ms_pkg::S_IDLE;
         sshift_reg <= 8'h00;
         scnt_reg <= 4'h0;
         s_rw_reg <= 1'b0;
         s_first_reg <= 1'b0;
         s_match_reg <= 1'b0;
         s_sda_low_reg <= 1'b0;
         s_rx1_reg <= i2c_ms_pkg::RDATA_RST;
         s_rx2_reg <= i2c_ms_pkg::RDATA_RST;
         s_tx_ev <= 1'b0;
         s_rx1_ev <= 1'b0;
         s_rx2_ev <= 1'b0;
      end else if (ce) begin
         s_tx_ev <= 1'b0;
         s_rx1_ev <= 1'b0;
         s_rx2_ev <= 1'b0;
         if (!s_en_reg || stop_det) begin
            s_state_reg <= i2c_ms_pkg::S_IDLE; // [RQ11]
            s_sda_low_reg <= 1'b0;
         end else if (start_det) begin
            s_state_reg <= i2c_ms_pkg::S_ADDR;
            scnt_reg <= 4'h0;
            s_match_reg <= 1'b0;
            s_first_reg <= 1'b1;
            s_sda_low_reg <= 1'b0;
         end else begin
            case (s_state_reg)
               i2c_ms_pkg::S_ADDR, i2c_ms_pkg::S_RX: begin
                  if (rise && !scnt_reg[3]) begin
                     sshift_reg <= rx_byte;
                     scnt_reg <= scnt_reg + 4'h1;
                     if (scnt_reg == 4'h7) begin
                        if (s_state_reg == i2c_ms_pkg::S_ADDR) begin
                           s_match_reg <= rx_byte[7:1]
                              == own_addr_reg; // [RQ10]
                           s_rw_reg <= rx_byte[0];
                        end else begin
                           s_match_reg <= 1'b1;
                           s_first_reg <= 1'b0;
                           if (s_first_reg) begin
                              s_rx1_reg <= rx_byte;
                              s_rx1_ev <= 1'b1;
                           end else begin
                              s_rx2_reg <= rx_byte; // [RQ17]
                              s_rx2_ev <= 1'b1;
                           end
                        end
                     end
                  end else if (fall && scnt_reg[3]) begin
                     if (s_match_reg) begin
                        s_sda_low_reg <= 1'b1;
                        s_state_reg <= i2c_ms_pkg::S_ACK;
                     end else begin
                        s_state_reg <= i2c_ms_pkg::S_IDLE;
                     end
                  end
               end
               i2c_ms_pkg::S_ACK: if (fall) begin
                  scnt_reg <= 4'h0;
                  sshift_reg <= s_tx_reg;
                  s_sda_low_reg <= s_rw_reg & ~s_tx_reg[7];
                  s_state_reg <= s_rw_reg ? i2c_ms_pkg::S_TX
                     : i2c_ms_pkg::S_RX;
               end
               i2c_ms_pkg::S_TX: begin
                  if (rise)
                     scnt_reg <= scnt_reg + 4'h1;
                  else if (fall && scnt_reg[3]) begin
                     s_sda_low_reg <= 1'b0;
                     s_state_reg <= i2c_ms_pkg::S_TXACK;
                  end else if (fall) begin
                     sshift_reg <= {sshift_reg[6:0], 1'b0};
                     s_sda_low_reg <= ~sshift_reg[6];
                  end
               end
               i2c_ms_pkg::S_TXACK: if (rise) begin
                  s_tx_ev <= 1'b1; // [RQ16]
                  s_state_reg <= sda_s2 ? i2c_ms_pkg::S_IDLE
                     : i2c_ms_pkg::S_ACK;
               end
               default: s_sda_low_reg <= 1'b0;
            endcase
         end
      end
   end

   // Interrupt status, clear and enable
   assign ev = {s_rx1_ev, s_rx2_ev, s_tx_ev, m_done_ev};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_reg <= '0;
         ien_reg <= '0;
      end else if (ce) begin
         if (wr && hit(paddr, i2c_ms_pkg::IEN_IDX))
            ien_reg <= pwdata[i2c_ms_pkg::EV_N-1:0];
         if (wr && hit(paddr, i2c_ms_pkg::ICLR_IDX))
            istat_reg <= ev | (istat_reg & ~pwdata[i2c_ms_pkg::EV_N-1:0]);
         else
            istat_reg <= ev | istat_reg;
      end
   end

   // Level interrupt; pad drive registered so outputs are flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
         pad_reg <= 4'b0101;
      end else if (ce) begin
         irq_reg <= (m_done_reg & s_ie_reg[3]) // [RQ12] [RQ18]
            | (s_slave_tx_done_flag_reg & s_ie_reg[2]) // [RQ13]
            | (s_rx2f_reg & s_ie_reg[1]) // [RQ14]
            | (s_rx1f_reg & s_ie_reg[0]) // [RQ15]
            | (|(istat_reg & ien_reg));
         pad_reg.scl_o <= 1'b0;
         pad_reg.sda_o <= 1'b0;
         pad_reg.scl_oe_n <= ~m_scl_low_reg;
         pad_reg.sda_oe_n <= ~(m_sda_low_reg | s_sda_low_reg);
      end
   end
endmodule : i2c_master_slave_regs

// File: test/i2c_peer_model.sv
/* Behavioural I2C peer device at one 7-bit address.
 Assumes wired-AND bus levels with pull-ups, sampled on pclk. */
`timescale 1ns/10ps
module i2c_peer_model #(
   parameter logic [6:0] PEER_ADDR = 7'h50
) (
   input wire logic pclk,
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] tx_byte,
   output logic sda_oe_n,
   output logic [7:0] rx_byte,
   output logic mack
);
   logic pscl = 1'b1, psda = 1'b1, first = 1'b0, rd = 1'b0, hit = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   initial sda_oe_n = 1'b1;
   always @(posedge pclk) begin
      pscl <= scl;
      psda <= sda;
      if (scl && pscl && psda && !sda) begin
         cnt <= 4'h0;
         first <= 1'b1;
         hit <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (scl && pscl && !psda && sda) begin
         hit <= 1'b0;
      end else if (scl && !pscl) begin
         sh <= {sh[6:0], sda};
         cnt <= cnt + 4'h1;
      end else if (!scl && pscl) begin
         if (cnt == 4'h8 && first) begin
            hit <= sh[7:1] == PEER_ADDR;
            rd <= sh[0];
            sda_oe_n <= sh[7:1] != PEER_ADDR;
         end else if (cnt == 4'h8) begin
            rx_byte <= rd ? rx_byte : sh;
            sda_oe_n <= rd || !hit;
         end else if (cnt == 4'h9) begin
            // A NACK from the master ends our sending
            cnt <= 4'h0;
            first <= 1'b0;
            mack <= sh[0];
            sda_oe_n <= !(hit && rd && (first || !sh[0])) || tx_byte[7];
         end else if (hit && rd && !first) begin
            sda_oe_n <= tx_byte[3'd7 - cnt[2:0]];
         end
      end
   end
endmodule : i2c_peer_model

// File: test/i2c_master_slave_regs_assertions.sv
/* Port checker for the I2C register block.
 Assumes one pclk domain; bound into the block below. */
`timescale 1ns/10ps
module i2c_ms_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire i2c_ms_pkg::pad_out_s pad_out,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   one_wait_a: assert property ($rose(penable) && psel && ce |=> pready)
      else $error("pready late");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("prdata upper bits set");
   bad_addr_err_a: assert property (pready && paddr == 10'h000 |-> pslverr)
      else $error("no error on unmapped");
   ctrl_addr_ok_a: assert property (pready && paddr == 10'h384 |-> !pslverr)
      else $error("error on control register");
   read_hold_a: assert property (!psel |=> $stable(prdata))
      else $error("prdata moved while idle");
   irq_clear_a: assert property ($fell(irq) |->
      $past(pwrite && pready, 1) || $past(pwrite && pready, 2))
      else $error("irq dropped without a write");
   cover property ($rose(irq));
   cover property ($rose(pslverr));
   cover property ($fell(pad_out.sda_oe_n) && pad_out.scl_oe_n);
endmodule : i2c_ms_checker
bind i2c_master_slave_regs i2c_ms_checker chk (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pad_out(pad_out), .irq(irq));

// File: test/i2c_master_slave_regs_tb.sv
/* Self-checking bench for the I2C register block.
 Assumes a peer model on the bus and APB master tasks here. */
`timescale 1ns/10ps
module i2c_master_slave_regs_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, err, irq, peer_oe_n, mack;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] tx, peer_rx, b, rate;
   logic [7:0] sent_q[$];
   logic [7:0] ri [5] = '{i2c_ms_pkg::MCTRL_IDX, i2c_ms_pkg::MDATA_IDX,
      i2c_ms_pkg::SADDR_IDX, i2c_ms_pkg::SCTRL_IDX, i2c_ms_pkg::ISTAT_IDX};
   logic [7:0] rv [5] = '{8'h04, 8'h00, 8'h64, 8'h04, 8'h00};
   i2c_ms_pkg::pad_out_s po;
   int errors = 0, n_checks = 0, cyc = 0, hi = 0;
   always #2 pclk = ~pclk;
   i2c_master_slave_regs uut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pad_in({po.scl_oe_n, po.sda_oe_n & peer_oe_n}), .pad_out(po),
      .irq(irq));
   i2c_peer_model peer (.pclk(pclk), .scl(po.scl_oe_n),
      .sda(po.sda_oe_n & peer_oe_n), .tx_byte(tx), .sda_oe_n(peer_oe_n),
      .rx_byte(peer_rx), .mack(mack));
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // Trailing idle edge keeps back-to-back calls race free
   task automatic apb(input logic [7:0] idx, input logic wr,
      input logic [7:0] wd);
      psel <= 1'b1;
      paddr <= {idx, 2'b00};
      pwrite <= wr;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic poll(input int n, input logic v);
      do apb(i2c_ms_pkg::MCTRL_IDX, 1'b0, 8'h00); while (rd[n] !== v);
   endtask : poll
   task automatic ctl(input logic [7:0] v);
      apb(i2c_ms_pkg::MCTRL_IDX, 1'b1, 8'h80 | v | rate);
   endtask : ctl
   task automatic send(input logic [7:0] d, input logic ea);
      apb(i2c_ms_pkg::MDATA_IDX, 1'b1, d);
      poll(5, 1'b1);
      chk("ack_in", {31'h0, ea}, {31'h0, rd[4]});
   endtask : send
   task automatic ck_irq(input logic e);
      repeat (2) @(posedge pclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask : ck_irq
   task automatic stopped();
      repeat (5 << 2 * rate) @(posedge pclk);
      chk("bus idle", 32'h3, {30'h0, po.scl_oe_n, po.sda_oe_n});
   endtask : stopped
   always @(posedge pclk) begin
      hi <= (po.scl_oe_n === 1'b1) ? hi + 1 : 0;
      if (po.scl_oe_n === 1'b0 && hi > 0 && hi < (4 << 2 * rate))
         chk("scl high", 2 << 2 * rate, hi);
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      b = 8'($urandom(32'h592c83a5));
      // Divide by 4 outruns the pin sync
      rate = (b[1:0] == 2'b00) ? 8'h01 : {6'h0, b[1:0]};
      tx = 8'($urandom);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         apb(ri[i], 1'b0, 8'h00);
         chk("reset", {24'h0, rv[i]}, rd);
      end
      apb(8'h00, 1'b0, 8'h00);
      chk("slverr", 32'h1, {31'h0, err});
      apb(i2c_ms_pkg::SCTRL_IDX, 1'b1, 8'h80);
      ctl(8'h08);
      poll(3, 1'b0);
      send(8'ha0, 1'b0);
      ck_irq(1'b1);
      ctl(8'h00);
      ck_irq(1'b0);
      b = 8'($urandom);
      sent_q.push_back(b);
      send(b, 1'b0);
      ctl(8'h00);
      chk("peer rx", sent_q.pop_front(), peer_rx);
      ctl(8'h08);
      poll(3, 1'b0);
      send(8'ha1, 1'b0);
      ctl(8'h40);
      apb(i2c_ms_pkg::MDATA_IDX, 1'b0, 8'h00);
      poll(5, 1'b1);
      chk("ack_out", 32'h1, {31'h0, mack});
      ctl(8'h04);
      stopped();
      apb(i2c_ms_pkg::MDATA_IDX, 1'b0, 8'h00);
      chk("rx byte", tx, rd);
      apb(i2c_ms_pkg::SADDR_IDX, 1'b1, 8'h65);
      ctl(8'h08);
      poll(3, 1'b0);
      send(8'h64, 1'b0);
      ctl(8'h00);
      b = 8'($urandom);
      send(b, 1'b0);
      ctl(8'h04);
      stopped();
      apb(i2c_ms_pkg::SRX1_IDX, 1'b0, 8'h00);
      chk("slave rx1", b, rd);
      apb(i2c_ms_pkg::SCTRL_IDX, 1'b1, 8'h17);
      ck_irq(1'b1);
      ctl(8'h08);
      poll(3, 1'b0);
      send(8'h22, 1'b1);
      apb(i2c_ms_pkg::SCTRL_IDX, 1'b1, 8'h00);
      apb(i2c_ms_pkg::IEN_IDX, 1'b1, 8'h01);
      ck_irq(1'b1);
      apb(i2c_ms_pkg::IEN_IDX, 1'b1, 8'h00);
      ck_irq(1'b0);
      ctl(8'h04);
      apb(i2c_ms_pkg::ICLR_IDX, 1'b1, 8'h01);
      apb(i2c_ms_pkg::ISTAT_IDX, 1'b0, 8'h00);
      chk("status", 32'h0, {31'h0, rd[0]});
      test_done();
   end
endmodule : i2c_master_slave_regs_tb
